/* dv/heavy_load_sub_detector_ctrl_test.sv */
// Self-checking bench for the heavy-load and detector control block
`timescale 1ns/1ps
`include "hls_defs.svh"
module heavy_load_sub_detector_ctrl_test;
	import hls_pkg::*;
	localparam int          ON     = 20;
	localparam int          SUB    = 4;
	localparam logic [11:0] A_MODE = 12'(`HLS_ADDR_MODE);
	localparam logic [11:0] A_DET  = 12'(`HLS_ADDR_DET);
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        tick_2hz = 1'b0;
	logic [3:0]  supply = 4'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, main_cmp_low, sub_cmp_low, detector_on;
	logic        heavy_load_mode, lcd_high_stability, lv_on, lv_mode, lv_lcd;
	logic        stopwatch_1hz_irq_mask, stopwatch_10hz_irq_mask;
	logic [2:0]  threshold_sel;
	logic [31:0] rd;
	logic        err;
	logic [3:0]  sup;
	int          n_errors = 0;
	int          check_count = 0;
	int          cyc = 0;
	integer      seed = 32'hab58255c;

	hls_ctrl #(.LOW_VOLTAGE(1'b0), .ON_CYC(ON)) dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .tick_2hz, .main_cmp_low, .sub_cmp_low,
		.detector_on, .threshold_sel, .heavy_load_mode, .lcd_high_stability,
		.stopwatch_1hz_irq_mask, .stopwatch_10hz_irq_mask
	);
	// Low-voltage variant on the same bus and comparators
	hls_ctrl #(.LOW_VOLTAGE(1'b1), .ON_CYC(ON)) dut_lv (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata(), .pready(), .pslverr(), .tick_2hz, .main_cmp_low,
		.sub_cmp_low, .detector_on(lv_on), .threshold_sel(),
		.heavy_load_mode(lv_mode), .lcd_high_stability(lv_lcd),
		.stopwatch_1hz_irq_mask(), .stopwatch_10hz_irq_mask()
	);
	hls_cmp_model #(.SUB_LVL(SUB)) u_cmp (
		.pclk, .detector_on, .threshold_sel, .supply,
		.main_cmp_low, .sub_cmp_low
	);

	////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #20 pclk = ~pclk;
	end

	// Whole run needs a few hundred cycles; a hang ends here
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors = n_errors + 1;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	function automatic logic exp_main(input logic [3:0] s, input logic [2:0] t);
		return s <= {1'b0, t};
	endfunction : exp_main

	function automatic logic exp_sub(input logic [3:0] s);
		return s < 4'(SUB);
	endfunction : exp_sub

	task automatic chk_reg(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_reg

	task automatic chk_bit(input string what, input logic exp, input logic got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic tick();
		@(posedge pclk);
		tick_2hz <= 1'b1;
		@(posedge pclk);
		tick_2hz <= 1'b0;
	endtask : tick

	task automatic tally_and_finish();
		if (n_errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, A_MODE, 32'h0);
		chk_reg("mode reset", 32'h0, rd);
		chk_bit("mode err", 1'b0, err);
		apb(1'b0, A_DET, 32'h0);
		chk_reg("det reset", 32'h0, rd);
		apb(1'b1, A_MODE, 32'h7);
		apb(1'b0, A_MODE, 32'h0);
		chk_reg("mode ro bit", 32'h3, rd);
		chk_bit("mask 1hz", 1'b1, stopwatch_1hz_irq_mask);
		chk_bit("mask 10hz", 1'b1, stopwatch_10hz_irq_mask);
		apb(1'b0, 12'h004, 32'h0);
		chk_bit("unmapped err", 1'b1, err);
		chk_reg("unmapped data", 32'h0, rd);
		// Every threshold code, a random supply level each time
		for (int i = 0; i < 8; i++) begin
			sup = 4'($random(seed));
			supply <= sup;
			apb(1'b1, A_DET, 32'(8 + i)); // Whole-word write
			repeat (ON + 10) @(posedge pclk); // Held past settling
			chk_bit("det on", 1'b1, detector_on);
			chk_reg("thr", 32'(i), 32'(threshold_sel));
			apb(1'b1, A_DET, 32'(i));
			apb(1'b0, A_DET, 32'h0);
			chk_reg("det read", {28'h0, exp_main(sup, 3'(i)), 3'(i)}, rd);
			apb(1'b0, A_MODE, 32'h0);
			chk_reg("sub", {28'h0, 1'b0, exp_sub(sup), 2'b11}, rd);
		end
		supply <= 4'h2;
		apb(1'b1, A_MODE, 32'hb);
		repeat (2) @(posedge pclk);
		chk_bit("hl mode", 1'b1, heavy_load_mode);
		chk_bit("lcd hs", 1'b1, lcd_high_stability);
		repeat (ON + 10) @(posedge pclk); // Settled before read
		apb(1'b0, A_MODE, 32'h0);
		chk_reg("entry sub", 32'hf, rd);
		apb(1'b0, A_DET, 32'h0);
		chk_reg("entry main", 32'hf, rd);
		apb(1'b1, A_MODE, 32'h3);
		repeat (2) @(posedge pclk);
		chk_bit("hl release", 1'b0, heavy_load_mode);
		chk_bit("lcd low", 1'b0, lcd_high_stability);
		chk_bit("auto mode", 1'b1, lv_mode);
		chk_bit("lcd lv", 1'b0, lv_lcd);
		tick();
		repeat (6) @(posedge pclk);
		chk_bit("auto sample", 1'b1, detector_on);
		chk_bit("lv sample", 1'b1, lv_on);
		repeat (ON + 10) @(posedge pclk);
		supply <= 4'hf;
		tick();
		repeat (ON + 10) @(posedge pclk);
		apb(1'b0, A_MODE, 32'h0);
		chk_reg("recovered", 32'h3, rd);
		chk_bit("auto end", 1'b0, lv_mode);
		tick();
		repeat (6) @(posedge pclk);
		chk_bit("sampling stopped", 1'b0, detector_on);
		tally_and_finish();
	end
endmodule : heavy_load_sub_detector_ctrl_test

/* dv/hls_cmp_model.sv */
// Behavioural model of the main and sub supply comparators
`timescale 1ns/1ps
module hls_cmp_model #(
	parameter int SETTLE  = 8,
	parameter int SUB_LVL = 4
) (
	input  wire logic       pclk,
	input  wire logic       detector_on,
	input  wire logic [2:0] threshold_sel,
	input  wire logic [3:0] supply,
	output logic            main_cmp_low,
	output logic            sub_cmp_low
);
	int   on_cnt = 0;
	logic junk   = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// One enable powers both comparators, so they settle together
	always @(posedge pclk) begin
		junk <= ~junk;
		on_cnt <= detector_on ? on_cnt + 1 : 0;
	end

	// Unpowered or unsettled outputs toggle, so no stale level helps
	always_comb begin
		if (on_cnt < SETTLE) begin
			main_cmp_low = junk;
			sub_cmp_low  = ~junk;
		end else begin
			main_cmp_low = supply <= {1'b0, threshold_sel};
			sub_cmp_low  = supply < 4'(SUB_LVL);
		end
	end
endmodule : hls_cmp_model

/* verilog/hls_ctrl.sv */
// Heavy-load mode and detector control with APB register access
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "hls_defs.svh"

// Operation
// - Enable write and result read share one bit; no read-modify-write.
// - Writing mode select one enters heavy-load mode, zero releases it.
// - Low-voltage variant: low sub result forces heavy-load until recovery.
// - Sub detector samples together with main detector, same enable timing.
// - Standard variant: software entry only; mode drives LCD high-stability.
// - Sub threshold fixed; mode select or enable times its latch updates.
// - Low-voltage auto mode samples both detectors on every 2 Hz tick.
// - Low-voltage auto mode ends when main detector reports recovered supply.
// - Standard variant: latched low sub result starts 2 Hz sampling.
// - Standard variant: recovered main result stops 2 Hz sampling.
// - Mode register bit 3 is mode select, read/write, reset zero.
// - Mode register bit 2 is sub result, read-only, reset zero.
// - Mode register bits 1 and 0 are stopwatch masks, reset zero.
// - Detector register bits 2..0 are three-bit threshold select.
// - Mode entry latches after one instruction, then on each 2 Hz sample.
// - Detector runs while enable is one; latch loads when it clears.
module hls_ctrl
	import hls_pkg::*;
#(
	parameter bit LOW_VOLTAGE = 1'b0,
	parameter int ON_CYC      = `HLS_DET_ON_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        tick_2hz,
	input  wire logic        main_cmp_low,
	input  wire logic        sub_cmp_low,
	output logic             detector_on,
	output logic [2:0]       threshold_sel,
	output logic             heavy_load_mode,
	output logic             lcd_high_stability,
	output logic             stopwatch_1hz_irq_mask,
	output logic             stopwatch_10hz_irq_mask
);

	hls_ctrl_st_t st_ff;
	hls_ctrl_st_t nxt_st;
	hls_smp_if    smp_if ();

	logic wr_mode;
	logic wr_det;
	logic rd_det;
	logic periodic;
	logic do_latch;
	logic bls_fall;
	logic [1:0] hit;

	function automatic logic [1:0] dec_addr(input logic [11:0] a);
		dec_addr = {a == 12'(`HLS_ADDR_DET), a == 12'(`HLS_ADDR_MODE)};
	endfunction : dec_addr

	////////////////////////////////////////////////////////////////////////
	hls_sampler #(
		.ON_CYC (ON_CYC)
	) u_sampler (
		.pclk    (pclk),
		.presetn (presetn),
		.smp     (smp_if.smp)
	);

	assign smp_if.start = st_ff.start;

	////////////////////////////////////////////////////////////////////////
	// Writes land at the access edge only, when pready is already high
	assign hit     = dec_addr(paddr);
	assign wr_mode = psel && penable && pwrite && st_ff.pready && hit[0];
	assign wr_det  = psel && penable && pwrite && st_ff.pready && hit[1];
	assign rd_det  = psel && !penable && !pwrite && hit[1];

	// Periodic sampling runs in heavy-load mode or after a low sub result
	assign periodic = st_ff.hl_sel || st_ff.trig;
	assign bls_fall = wr_det && st_ff.det_en &&
		!pwdata[`HLS_B_DETEN];
	assign do_latch = smp_if.done || bls_fall;

	always_comb begin
		nxt_st         = st_ff;
		nxt_st.pready  = 1'b0;
		nxt_st.pslverr = 1'b0;
		nxt_st.start   = 1'b0;

		// Comparator outputs are asynchronous to pclk
		nxt_st.main_sync = {st_ff.main_sync[0], main_cmp_low};
		nxt_st.sub_sync  = {st_ff.sub_sync[0], sub_cmp_low};

		// Prescaler output is on pclk; only its rising edge is used
		nxt_st.tick_d   = tick_2hz;
		nxt_st.tick_stb = tick_2hz && !st_ff.tick_d;

		// Setup phase: answer in the next cycle, zero wait states
		if (psel && !penable) begin
			nxt_st.pready  = 1'b1;
			nxt_st.pslverr = (dec_addr(paddr) == 2'b00);
			nxt_st.prdata  = 32'h0000_0000;
			if (!pwrite && hit[0]) begin
				nxt_st.prdata[`HLS_B_HLSEL]  = st_ff.hl_sel;
				nxt_st.prdata[`HLS_B_SUBRES] = st_ff.sub_res;
				nxt_st.prdata[`HLS_B_SW1]    = st_ff.sw1_msk;
				nxt_st.prdata[`HLS_B_SW10]   = st_ff.sw10_msk;
			end
			if (rd_det) begin
				// Enable is write-only; reads see the latch
				nxt_st.prdata[`HLS_B_DETEN] = st_ff.main_res;
				nxt_st.prdata[`HLS_THR_W-1:0] = st_ff.thr;
			end
		end

		if (wr_mode) begin
			nxt_st.hl_sel   = pwdata[`HLS_B_HLSEL];
			nxt_st.sw1_msk  = pwdata[`HLS_B_SW1];
			nxt_st.sw10_msk = pwdata[`HLS_B_SW10];
			// Sub result bit ignores writes
			if (pwdata[`HLS_B_HLSEL] && !st_ff.hl_sel) begin
				nxt_st.start = 1'b1;
			end
		end
		if (wr_det) begin
			nxt_st.det_en = pwdata[`HLS_B_DETEN];
			nxt_st.thr    = pwdata[`HLS_B_THR +: `HLS_THR_W];
		end

		if (st_ff.tick_stb && periodic) begin
			nxt_st.start = 1'b1;
		end

		// Both latches load on the same strobe
		if (do_latch) begin
			nxt_st.main_res = st_ff.main_sync[1];
			nxt_st.sub_res  = st_ff.sub_sync[1];
			// A low sub result wins over a recovered main result
			if (st_ff.sub_sync[1]) begin
				nxt_st.trig = 1'b1;
			end else if (!st_ff.main_sync[1]) begin
				nxt_st.trig = 1'b0;
			end
		end

		// Fixed sub threshold: no field steers it
		nxt_st.det_on = nxt_st.det_en || smp_if.busy;
		nxt_st.hl_eff = nxt_st.hl_sel ||
			(LOW_VOLTAGE && nxt_st.trig);
		nxt_st.lcd_hs = nxt_st.hl_eff && !LOW_VOLTAGE;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
			st_ff.hl_sel   <= 1'(`HLS_RST_MODE >> `HLS_B_HLSEL);
			st_ff.thr      <= `HLS_RST_THR;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign prdata                  = st_ff.prdata;
	assign pready                  = st_ff.pready;
	assign pslverr                 = st_ff.pslverr;
	assign detector_on             = st_ff.det_on;
	assign threshold_sel           = st_ff.thr;
	assign heavy_load_mode         = st_ff.hl_eff;
	assign lcd_high_stability      = st_ff.lcd_hs;
	assign stopwatch_1hz_irq_mask  = st_ff.sw1_msk;
	assign stopwatch_10hz_irq_mask = st_ff.sw10_msk;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_hl_write;
		wr_mode |=> st_ff.hl_sel == $past(pwdata[`HLS_B_HLSEL]);
	endproperty
	a_hl_write: assert property (p_hl_write)
		else $error("Mode select did not follow write");

	property p_sub_ro;
		wr_mode && !do_latch |=> $stable(st_ff.sub_res);
	endproperty
	a_sub_ro: assert property (p_sub_ro)
		else $error("Sub result changed by a write");

	property p_entry_sample;
		wr_mode && pwdata[`HLS_B_HLSEL] && !st_ff.hl_sel
			|=> st_ff.start ##1 smp_if.busy;
	endproperty
	a_entry_sample: assert property (p_entry_sample)
		else $error("Mode entry did not start a sample");

	property p_tick_sample;
		st_ff.tick_stb && periodic |=> st_ff.start;
	endproperty
	a_tick_sample: assert property (p_tick_sample)
		else $error("2 Hz tick missed while sampling active");

	property p_no_tick_sample;
		st_ff.tick_stb && !periodic && !wr_mode |=> !st_ff.start;
	endproperty
	a_no_tick_sample: assert property (p_no_tick_sample)
		else $error("Periodic sample while inactive");

	property p_det_on;
		smp_if.busy |=> st_ff.det_on;
	endproperty
	a_det_on: assert property (p_det_on)
		else $error("Detector off during a timed run");

	property p_bls_latch;
		bls_fall |=> st_ff.main_res == $past(st_ff.main_sync[1]) &&
			st_ff.sub_res == $past(st_ff.sub_sync[1]);
	endproperty
	a_bls_latch: assert property (p_bls_latch)
		else $error("Latch not loaded when enable cleared");

	property p_rd_main;
		rd_det |=> prdata[`HLS_B_DETEN] == $past(st_ff.main_res);
	endproperty
	a_rd_main: assert property (p_rd_main)
		else $error("Read did not return main latch");

	property p_auto_mode;
		do_latch && st_ff.sub_sync[1] |=> ##1
			(heavy_load_mode == (LOW_VOLTAGE || st_ff.hl_sel));
	endproperty
	a_auto_mode: assert property (p_auto_mode)
		else $error("Effective mode not select OR sub low");

	property p_lcd;
		$rose(st_ff.hl_sel) && !LOW_VOLTAGE |-> lcd_high_stability;
	endproperty
	a_lcd: assert property (p_lcd)
		else $error("LCD not in high stability in heavy load");

	property p_recover;
		do_latch && !st_ff.sub_sync[1] && !st_ff.main_sync[1]
			|=> !st_ff.trig;
	endproperty
	a_recover: assert property (p_recover)
		else $error("Recovered supply did not end auto sampling");

	property p_apb_ready;
		psel && !penable |=> pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready)
		else $error("No answer in access phase");

	property p_unmapped;
		psel && !penable && hit == 2'b00
			|=> pslverr && prdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("Unmapped access not refused");

	property p_std_sw_only;
		!LOW_VOLTAGE |-> heavy_load_mode == st_ff.hl_sel;
	endproperty
	a_std_sw_only: assert property (p_std_sw_only)
		else $error("Standard variant entered heavy load on its own");

	property p_lcd_lv;
		LOW_VOLTAGE |-> !lcd_high_stability;
	endproperty
	a_lcd_lv: assert property (p_lcd_lv)
		else $error("LCD high stability in low-voltage variant");

	property p_det_en_write;
		wr_det |=> st_ff.det_en == $past(pwdata[`HLS_B_DETEN]);
	endproperty
	a_det_en_write: assert property (p_det_en_write)
		else $error("Detector enable did not follow write");

	property p_thr_write;
		wr_det |=>
			threshold_sel == $past(pwdata[`HLS_B_THR +: `HLS_THR_W]);
	endproperty
	a_thr_write: assert property (p_thr_write)
		else $error("Threshold select did not follow write");

	property p_mask_write;
		wr_mode |=>
			stopwatch_1hz_irq_mask == $past(pwdata[`HLS_B_SW1]) &&
			stopwatch_10hz_irq_mask == $past(pwdata[`HLS_B_SW10]);
	endproperty
	a_mask_write: assert property (p_mask_write)
		else $error("Stopwatch masks did not follow write");

	property p_latch_hold;
		!do_latch |=> $stable(st_ff.main_res) && $stable(st_ff.sub_res);
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("Detector latch changed without a strobe");

	c_entry:    cover property (wr_mode && pwdata[`HLS_B_HLSEL]);
	c_periodic: cover property (st_ff.tick_stb && st_ff.trig);
	c_bls:      cover property (bls_fall);
	c_recover:  cover property (st_ff.trig ##1 !st_ff.trig);

endmodule : hls_ctrl

/* verilog/hls_defs.svh */
// Offsets, field positions, reset values and timing counts of the block
`ifndef HLS_DEFS_SVH
`define HLS_DEFS_SVH

// Register indices; byte address is four times the index
`define HLS_IDX_MODE       12'h2e6
`define HLS_IDX_DET        12'h2ff
`define HLS_ADDR_MODE      (`HLS_IDX_MODE * 4)
`define HLS_ADDR_DET       (`HLS_IDX_DET * 4)

// Mode and stopwatch mask register fields
`define HLS_B_HLSEL        3
`define HLS_B_SUBRES       2
`define HLS_B_SW1          1
`define HLS_B_SW10         0

// Detector enable and threshold register fields
`define HLS_B_DETEN        3
`define HLS_B_THR          0
`define HLS_THR_W          3

// Reset values
`define HLS_RST_MODE       4'h0
`define HLS_RST_THR        3'h0

// Timing
`define HLS_CLK_NS         40
`define HLS_DET_ON_NS      100000
`define HLS_DET_ON_CYC     ((`HLS_DET_ON_NS + `HLS_CLK_NS - 1) / `HLS_CLK_NS)

`endif

/* verilog/hls_pkg.sv */
// Types shared by the heavy-load and detector control block
package hls_pkg;

	typedef enum logic [1:0] {
		HLS_S_IDLE = 2'b01,
		HLS_S_RUN  = 2'b10
	} hls_smp_state_t;

	typedef struct packed {
		hls_smp_state_t state;
		logic [15:0]    cnt;
		logic           busy;
		logic           done;
	} hls_smp_st_t;

	typedef struct packed {
		logic        hl_sel;
		logic        sw1_msk;
		logic        sw10_msk;
		logic        det_en;
		logic [2:0]  thr;
		logic        main_res;
		logic        sub_res;
		logic        trig;
		logic [1:0]  main_sync;
		logic [1:0]  sub_sync;
		logic        tick_d;
		logic        tick_stb;
		logic        start;
		logic        det_on;
		logic        hl_eff;
		logic        lcd_hs;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} hls_ctrl_st_t;

endpackage : hls_pkg

/* verilog/hls_sampler.sv */
// Timed detector run: holds the detector on, then strobes the latch
`timescale 1ns/1ps
`include "hls_defs.svh"
module hls_sampler
	import hls_pkg::*;
#(
	parameter int ON_CYC = `HLS_DET_ON_CYC
) (
	input  wire logic pclk,
	input  wire logic presetn,
	hls_smp_if.smp    smp
);

	hls_smp_st_t st_ff;
	hls_smp_st_t nxt_st;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_st      = st_ff;
		nxt_st.done = 1'b0;
		case (st_ff.state)
			HLS_S_IDLE: begin
				// A start while running is dropped; the run in flight
				// already covers the same sample
				if (smp.start) begin
					nxt_st.state = HLS_S_RUN;
					nxt_st.busy  = 1'b1;
					nxt_st.cnt   = 16'h0000;
				end
			end
			HLS_S_RUN: begin
				if (st_ff.cnt == 16'(ON_CYC - 1)) begin
					nxt_st.state = HLS_S_IDLE;
					nxt_st.busy  = 1'b0;
					nxt_st.done  = 1'b1;
				end else begin
					nxt_st.cnt = st_ff.cnt + 16'h0001;
				end
			end
			default: begin
				nxt_st.state = HLS_S_IDLE;
				nxt_st.busy  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '{state: HLS_S_IDLE, cnt: 16'h0000,
				busy: 1'b0, done: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign smp.busy = st_ff.busy;
	assign smp.done = st_ff.done;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_run_min;
		$rose(st_ff.busy) |-> st_ff.busy [*8];
	endproperty
	a_run_min: assert property (p_run_min)
		else $error("Detector run shorter than minimum");

	property p_done_at_end;
		st_ff.done |-> $past(st_ff.cnt) == 16'(ON_CYC - 1);
	endproperty
	a_done_at_end: assert property (p_done_at_end)
		else $error("Latch strobe before full on time");

endmodule : hls_sampler

/* verilog/hls_smp_if.sv */
// Handshake between the controller and the timed sampler
`timescale 1ns/1ps
interface hls_smp_if;
	logic start;
	logic busy;
	logic done;

	modport ctrl (output start, input busy, input done);
	modport smp  (input start, output busy, output done);
endinterface : hls_smp_if
